/* sysref_cal_regs.vh */
`ifndef SYSREF_CAL_REGS_VH
`define SYSREF_CAL_REGS_VH

// ****************************************
// Register indices (byte address = 4 * index)
// ****************************************
`define IDX_CAL_EN 10'h2b0
`define IDX_CAL_CFG 10'h2b1
`define IDX_CAL_RESULT 10'h2b2
`define IDX_DELAY_ADJ 10'h2b5
`define IDX_RAMP_CTRL 10'h2b8
`define IDX_CAL_STATE 10'h2b9

// ****************************************
// Field positions
// ****************************************
`define CAL_EN_BIT 0
`define AVG_LSB 2
`define HDUR_LSB 0
`define COMPLETE_BIT 17
`define INV_BIT 16
`define COARSE_LSB 8
`define FINE_LSB 0
`define RAMP_EN_BIT 0
`define RAMP_FAST_BIT 1
`define STATE_BUSY_BIT 0
`define STATE_FAIL_BIT 1

// ****************************************
// Reset values
// ****************************************
`define CAL_EN_RST 8'h00
`define CAL_CFG_RST 8'h05
`define DELAY_ADJ_RST 24'h00_0000
`define RAMP_CTRL_RST 8'h00

// ****************************************
// Timing counts in device-clock cycles; ramp step sizes in delay codes
// ****************************************
`define RAMP_TICK 8'hff
`define RAMP_STEP_SLOW 8'h01
`define RAMP_STEP_FAST 8'h04
`define PERIOD_MAX_0 16'h0055
`define PERIOD_MAX_1 16'h044c
`define PERIOD_MAX_2 16'h1450
`define PERIOD_MAX_3 16'h544c
`define TIMEOUT_SCALE 32'h0000_1300

`endif

/* sysref_phase_accum.v */
`timescale 1ns/10ps
`include "sysref_cal_regs.vh"

module sysref_phase_accum #(
   parameter [31:0] TIMEOUT_SCALE = `TIMEOUT_SCALE
) (
   input wire ref_clk_i,
   input wire rst_i,
   input wire start_i,
   input wire abort_i,
   input wire [1:0] avg_code_i,
   input wire [1:0] dur_code_i,
   input wire sysref_i,
   output wire busy_o,
   output reg done_o,
   output reg fail_o,
   output reg [16:0] result_o
);

   function [8:0] code_len;
      input [1:0] c;
      begin
         code_len = 9'h004 << {c, 1'b0};
      end
   endfunction

   function [15:0] period_limit;
      input [1:0] c;
      begin
         case (c)
            2'd0: period_limit = `PERIOD_MAX_0;
            2'd1: period_limit = `PERIOD_MAX_1;
            2'd2: period_limit = `PERIOD_MAX_2;
            default: period_limit = `PERIOD_MAX_3;
         endcase
      end
   endfunction

   reg busy_q;
   reg [1:0] avg_q;
   reg [1:0] dur_q;
   reg [8:0] win_cnt_q;
   reg [8:0] acc_cnt_q;
   reg [16:0] sum_q;
   reg [15:0] per_cnt_q;
   reg sr_prev_q;
   reg [31:0] tmo_q;

   wire [2:0] ah = {1'b0, avg_q} + {1'b0, dur_q};
   wire [3:0] tmo_exp = {1'b0, ah} + 4'd2;
   wire [2:0] rs = 3'd6 - ah;
   wire [31:0] tmo_lim = TIMEOUT_SCALE << {tmo_exp, 1'b0};
   wire [16:0] sum_nx = sum_q + {16'h0000, sysref_i};
   wire win_end = (win_cnt_q == code_len(dur_q) - 9'd1);
   wire last_win = (acc_cnt_q == code_len(avg_q) - 9'd1);
   wire edge_seen = sysref_i & ~sr_prev_q;
   wire per_bad = ~edge_seen & (per_cnt_q >= period_limit(dur_q));
   wire tmo_bad = (tmo_q >= tmo_lim - 32'd1);

   assign busy_o = busy_q;

   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         busy_q <= 1'b0;
         avg_q <= 2'd0;
         dur_q <= 2'd0;
         win_cnt_q <= 9'd0;
         acc_cnt_q <= 9'd0;
         sum_q <= 17'h0_0000;
         per_cnt_q <= 16'h0000;
         sr_prev_q <= 1'b0;
         tmo_q <= 32'h0000_0000;
         done_o <= 1'b0;
         fail_o <= 1'b0;
         result_o <= 17'h0_0000;
      end else begin
         done_o <= 1'b0;
         fail_o <= 1'b0;
         sr_prev_q <= sysref_i;
         if (start_i) begin
            busy_q <= 1'b1;
            avg_q <= avg_code_i;
            dur_q <= dur_code_i;
            win_cnt_q <= 9'd0;
            acc_cnt_q <= 9'd0;
            sum_q <= 17'h0_0000;
            per_cnt_q <= 16'h0000;
            tmo_q <= 32'h0000_0000;
         end else if (abort_i) begin
            busy_q <= 1'b0;
         end else if (busy_q) begin
            tmo_q <= tmo_q + 32'd1;
            per_cnt_q <= edge_seen ? 16'h0000 : per_cnt_q + 16'h0001;
            sum_q <= sum_nx;
            win_cnt_q <= win_end ? 9'd0 : win_cnt_q + 9'd1;
            if (win_end)
               acc_cnt_q <= acc_cnt_q + 9'd1;
            if (per_bad | tmo_bad) begin
               busy_q <= 1'b0;
               fail_o <= 1'b1;
            end else if (win_end & last_win) begin
               busy_q <= 1'b0;
               done_o <= 1'b1;
               result_o <= sum_nx << {rs, 1'b0};
            end
         end
      end
   end

endmodule // sysref_phase_accum

/* sysref_aperture_delay_cal.v */
`timescale 1ns/10ps
`include "sysref_cal_regs.vh"

module sysref_aperture_delay_cal #(
   parameter [31:0] CAL_TIMEOUT_SCALE = `TIMEOUT_SCALE
) (
   input wire ref_clk_i,
   input wire rst_i,
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [11:0] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i,
   output reg [31:0] dat_o,
   output reg ack_o,
   input wire sysref_i,
   output reg [16:0] aperture_delay_o,
   output wire clock_invert_o,
   output wire cal_complete_o
);

   // ****************************************
   // Helpers
   // ****************************************
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] sel;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (sel[i])
               merge[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
   endfunction

   function [7:0] step_toward;
      input [7:0] cur;
      input [7:0] tgt;
      input fast;
      reg [7:0] st;
      begin
         st = fast ? `RAMP_STEP_FAST : `RAMP_STEP_SLOW;
         if (cur < tgt)
            step_toward = (tgt - cur <= st) ? tgt : cur + st;
         else if (cur > tgt)
            step_toward = (cur - tgt <= st) ? tgt : cur - st;
         else
            step_toward = cur;
      end
   endfunction

   // ****************************************
   // Bus decode
   // ****************************************
   wire [9:0] idx = adr_i[11:2];
   wire req = cyc_i & stb_i & ~ack_o;
   wire wr = req & we_i;

   reg [7:0] en_reg_q;
   reg [7:0] cfg_q;
   reg [23:0] delay_q;
   reg [7:0] ramp_q;
   reg [7:0] coarse_app_q;
   reg [7:0] ramp_cnt_q;
   reg complete_q;
   reg fail_q;
   reg [31:0] rd_d;

   wire eng_busy;
   wire eng_done;
   wire eng_fail;
   wire [16:0] eng_result;

   wire [31:0] en_wr = merge({24'h00_0000, en_reg_q}, dat_i, sel_i);
   wire [31:0] cfg_wr = merge({24'h00_0000, cfg_q}, dat_i, sel_i);
   wire [31:0] dly_wr = merge({8'h00, delay_q}, dat_i, sel_i);
   wire [31:0] rmp_wr = merge({24'h00_0000, ramp_q}, dat_i, sel_i);

   wire cal_enable = en_reg_q[`CAL_EN_BIT];
   wire en_write = wr & (idx == `IDX_CAL_EN);
   wire cal_enable_d = en_write ? en_wr[`CAL_EN_BIT] : cal_enable;
   // rising enable edge starts a run
   wire cal_start = cal_enable_d & ~cal_enable;
   wire cal_abort = ~cal_enable_d;

   wire [1:0] avg_code = cfg_q[`AVG_LSB +: 2];
   wire [1:0] dur_code = cfg_q[`HDUR_LSB +: 2];
   wire [7:0] coarse_tgt = delay_q[`COARSE_LSB +: 8];
   wire [7:0] fine_set = delay_q[`FINE_LSB +: 8];
   wire inv_set = delay_q[`INV_BIT];
   wire ramp_en = ramp_q[`RAMP_EN_BIT];
   wire ramp_fast = ramp_q[`RAMP_FAST_BIT];
   wire ramp_tick = (ramp_cnt_q == `RAMP_TICK);

   assign cal_complete_o = cal_enable & complete_q;
   // bit 16 of the applied delay drives the clock invert
   assign clock_invert_o = aperture_delay_o[16];

   // ****************************************
   // Calibration engine
   // ****************************************
   sysref_phase_accum #(
      .TIMEOUT_SCALE(CAL_TIMEOUT_SCALE)
   ) u_accum (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .start_i(cal_start),
      .abort_i(cal_abort),
      .avg_code_i(avg_code),
      .dur_code_i(dur_code),
      .sysref_i(sysref_i),
      .busy_o(eng_busy),
      .done_o(eng_done),
      .fail_o(eng_fail),
      .result_o(eng_result)
   );

   // ****************************************
   // Register writes
   // ****************************************
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         en_reg_q <= `CAL_EN_RST;
         cfg_q <= `CAL_CFG_RST;
         delay_q <= `DELAY_ADJ_RST;
         ramp_q <= `RAMP_CTRL_RST;
      end else if (wr) begin
         case (idx)
            `IDX_CAL_EN: begin
               en_reg_q <= en_wr[7:0];
            end
            `IDX_CAL_CFG: begin
               cfg_q <= cfg_wr[7:0];
            end
            `IDX_DELAY_ADJ: begin
               delay_q <= dly_wr[23:0];
            end
            `IDX_RAMP_CTRL: begin
               ramp_q <= rmp_wr[7:0];
            end
            default: begin
               en_reg_q <= en_reg_q;
            end
         endcase
      end
   end

   // ****************************************
   // Completion and failure flags
   // ****************************************
   // A finish in the start cycle cannot occur: start restarts the engine
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         complete_q <= 1'b0;
         fail_q <= 1'b0;
      end else begin
         // complete cleared when a run starts and while the enable is off; fail cleared only when a run starts
         if (eng_done)
            complete_q <= 1'b1;
         else if (cal_start | cal_abort)
            complete_q <= 1'b0;
         if (eng_fail)
            fail_q <= 1'b1;
         else if (cal_start)
            fail_q <= 1'b0;
      end
   end

   // ****************************************
   // Coarse delay ramp
   // ****************************************
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         ramp_cnt_q <= 8'h00;
         coarse_app_q <= 8'h00;
      end else begin
         ramp_cnt_q <= ramp_cnt_q + 8'h01;
         if (!ramp_en) begin
            // immediate apply, well inside the bound
            coarse_app_q <= coarse_tgt;
         end else if (ramp_tick) begin
            // one or four codes per 256 cycles
            coarse_app_q <= step_toward(coarse_app_q, coarse_tgt, ramp_fast);
         end
      end
   end

   // ****************************************
   // Applied aperture delay
   // ****************************************
   // Manual setting keeps tracking while disabled so re-entry is glitch free
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         aperture_delay_o <= 17'h0_0000;
      end else if (cal_enable) begin
         if (complete_q)
            aperture_delay_o <= eng_result;
      end else begin
         // coarse and fine under manual control
         aperture_delay_o <= {inv_set, coarse_app_q, fine_set};
      end
   end

   // ****************************************
   // Read mux and acknowledge
   // ****************************************
   always @* begin
      rd_d = 32'h0000_0000;
      case (idx)
         `IDX_CAL_EN: rd_d = {24'h00_0000, en_reg_q};
         `IDX_CAL_CFG: rd_d = {24'h00_0000, cfg_q};
         `IDX_CAL_RESULT: begin
            rd_d[`COMPLETE_BIT] = cal_complete_o;
            rd_d[16:0] = eng_result;
         end
         `IDX_DELAY_ADJ: rd_d = {8'h00, delay_q};
         `IDX_RAMP_CTRL: rd_d = {24'h00_0000, ramp_q};
         `IDX_CAL_STATE: begin
            rd_d[`STATE_BUSY_BIT] = eng_busy;
            rd_d[`STATE_FAIL_BIT] = fail_q;
         end
         default: rd_d = 32'h0000_0000;
      endcase
   end

   // Unmapped addresses still ack, reading zero, so the bus never hangs
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= req;
         if (req & ~we_i)
            dat_o <= rd_d;
      end
   end

endmodule // sysref_aperture_delay_cal

/* cal_asserts.sv */
`timescale 1ns/10ps
module cal_asserts #(
   parameter [31:0] CAL_TIMEOUT_SCALE = 32'h0000_1300
) (
   input wire ref_clk_i,
   input wire rst_i,
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [11:0] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i,
   input wire [31:0] dat_o,
   input wire ack_o,
   input wire sysref_i,
   input wire [16:0] aperture_delay_o,
   input wire clock_invert_o,
   input wire cal_complete_o
);
   reg en_q;
   reg ramp_q;
   reg [7:0] fine_q;
   wire wr = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   // Shadow of the enable, ramp and fine bits, taken at the same edge as the design
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         en_q <= 1'b0;
         ramp_q <= 1'b0;
         fine_q <= 8'h00;
      end else if (wr) begin
         if (adr_i == 12'hac0) en_q <= dat_i[0];
         if (adr_i == 12'hae0) ramp_q <= dat_i[0];
         if (adr_i == 12'had4) fine_q <= dat_i[7:0];
      end
   end
   ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack held too long");
   ack_resp_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack missing");
   inv_follow_a: assert property (clock_invert_o == aperture_delay_o[16])
      else $error("invert output differs from delay bit 16");
   fine_apply_a: assert property (wr && adr_i == 12'had4 && !en_q
      |-> ##[1:4] aperture_delay_o[7:0] == fine_q) else $error("fine delay not applied");
   complete_off_a: assert property (!en_q |-> !cal_complete_o)
      else $error("complete while disabled");
   run_clear_a: assert property ($rose(en_q) |-> !cal_complete_o [*8])
      else $error("complete during run");
   run_hold_a: assert property ($rose(en_q) |-> $stable(aperture_delay_o) [*8])
      else $error("delay moved during run");
   ramp_gap_a: assert property (ramp_q && !en_q && $changed(aperture_delay_o[15:8])
      |=> $stable(aperture_delay_o[15:8]) [*8]) else $error("ramp steps too close");
   cover property ($rose(cal_complete_o));
   cover property (ramp_q && $changed(aperture_delay_o[15:8]));
   cover property (wr && adr_i == 12'had4);
endmodule // cal_asserts

bind sysref_aperture_delay_cal cal_asserts #(.CAL_TIMEOUT_SCALE(CAL_TIMEOUT_SCALE)) u_asserts (
   .ref_clk_i(ref_clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
   .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
   .sysref_i(sysref_i), .aperture_delay_o(aperture_delay_o),
   .clock_invert_o(clock_invert_o), .cal_complete_o(cal_complete_o)
);

/* sysref_source.sv */
`timescale 1ns/10ps
module sysref_source (
   input wire ref_clk_i,
   input wire rst_i,
   input wire run_i,
   input wire [15:0] period_i,
   output reg sysref_o
);
   reg [15:0] cnt_q;
   // One-cycle pulse every period_i cycles; quiet low while stopped
   // period kept bounded
   always @(posedge ref_clk_i) begin
      if (rst_i || !run_i) begin
         cnt_q <= 16'h0000;
         sysref_o <= 1'b0;
      end else begin
         cnt_q <= (cnt_q == period_i - 16'h0001) ? 16'h0000 : cnt_q + 16'h0001;
         sysref_o <= (cnt_q == 16'h0000);
      end
   end
endmodule // sysref_source

/* tb_sysref_aperture_delay_cal.sv */
`timescale 1ns/10ps
module tb_sysref_aperture_delay_cal;
   logic ref_clk_i, rst_i, cyc_i, stb_i, we_i, run;
   logic [11:0] adr_i;
   logic [3:0] sel_i;
   logic [31:0] dat_i, rd;
   wire [31:0] dat_o;
   wire [16:0] aperture_delay_o;
   wire ack_o, sysref_i, clock_invert_o, cal_complete_o;
   int errors, checked, n, lim;
   // Address, write data, expected read-back
   logic [75:0] rows [8] = '{{12'had4, 32'hffff_ffff, 32'h00ff_ffff},
      {12'had4, 32'h0000_0000, 32'h0000_0000}, {12'hae0, 32'h0000_00fc, 32'h0000_00fc},
      {12'hae0, 32'h0000_0000, 32'h0000_0000}, {12'hac4, 32'h0000_00f5, 32'h0000_00f5},
      {12'hacc, 32'hffff_ffff, 32'h0000_0000}, {12'hac0, 32'h0000_00fe, 32'h0000_00fe},
      {12'hac0, 32'h0000_0000, 32'h0000_0000}};
   logic [43:0] rstv [4] = '{{12'hac0, 32'h0000_0000}, {12'hac4, 32'h0000_0005},
      {12'had4, 32'h0000_0000}, {12'hae0, 32'h0000_0000}};

   sysref_aperture_delay_cal #(.CAL_TIMEOUT_SCALE(32'h0000_0002)) DUT (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .sysref_i(sysref_i), .aperture_delay_o(aperture_delay_o),
      .clock_invert_o(clock_invert_o), .cal_complete_o(cal_complete_o));
   sysref_source u_src (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .run_i(run),
      .period_i(16'h0004), .sysref_o(sysref_i));

   initial begin
      ref_clk_i = 1'b0;
      forever #4 ref_clk_i = ~ref_clk_i;
   end

   task automatic stop_test;
      $display("errors=%0d checked=%0d", errors, checked);
      if (errors == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic check(input logic [31:0] s, input logic [31:0] e, input string m);
      checked++;
      if (s !== e) begin
         errors++;
         $display("[FAIL] %0t %s seen %h expected %h", $time, m, s, e);
      end
   endtask

   // Classic single cycle; held until ack is sampled high
   task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge ref_clk_i);
      {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, 4'hf, d};
      k = 0;
      do begin
         @(posedge ref_clk_i);
         k++;
      end while (ack_o !== 1'b1 && k < 20);
      rd = dat_o;
      {cyc_i, stb_i} <= 2'b00;
      if (k == 20) begin
         errors++;
         stop_test();
      end
   endtask

   task automatic rtime(input logic [7:0] tgt);
      n = 0;
      while (aperture_delay_o[15:8] !== tgt && n < 2000) begin
         @(posedge ref_clk_i);
         n++;
      end
   endtask

   task automatic cal(input logic [1:0] a, input logic [1:0] d);
      wb(1'b1, 12'hac4, {28'h0, a, d});
      wb(1'b1, 12'hac0, 32'h0000_0001);
      lim = (2 << (2 * (a + d + 2))) + 40;
      n = 0;
      while (cal_complete_o !== 1'b1 && n < lim) begin
         @(posedge ref_clk_i);
         n++;
      end
      if (n == lim) begin
         errors++;
         stop_test();
      end
      check(32'(n >= 4 ** (a + d + 2) - 4), 32'h1, "run too short");
      repeat (2) @(posedge ref_clk_i);
      check({15'h0, aperture_delay_o}, 32'h0000_4000, "cal delay");
      wb(1'b0, 12'hac8, 32'h0);
      check(rd, 32'h0002_4000, "cal status");
      wb(1'b1, 12'had4, 32'h0000_3300);
      repeat (4) @(posedge ref_clk_i);
      check({15'h0, aperture_delay_o}, 32'h0000_4000, "manual not ignored");
      wb(1'b1, 12'hac0, 32'h0);
      check({31'h0, cal_complete_o}, 32'h0, "complete after disable");
   endtask

   initial begin
      {rst_i, cyc_i, stb_i, we_i, run} = 5'b10000;
      adr_i = 12'h000;
      sel_i = 4'h0;
      dat_i = 32'h0000_0000;
      errors = 0;
      checked = 0;
      repeat (10) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      foreach (rows[i]) begin
         wb(1'b1, rows[i][75:64], rows[i][63:32]);
         wb(1'b0, rows[i][75:64], 32'h0);
         check(rd, rows[i][31:0], "read-back");
      end
      // Second reset, with no calibration running
      rst_i <= 1'b1;
      repeat (10) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      foreach (rstv[i]) begin
         wb(1'b0, rstv[i][43:32], 32'h0);
         check(rd, rstv[i][31:0], "reset value");
      end
      wb(1'b1, 12'had4, 32'h0001_225a);
      n = 0;
      while (aperture_delay_o !== 17'h1_225a && n < 1024) begin
         @(posedge ref_clk_i);
         n++;
      end
      check(32'(n < 1024), 32'h1, "manual delay late");
      check({31'h0, clock_invert_o}, 32'h1, "invert");
      wb(1'b1, 12'hae0, 32'h0000_0001);
      wb(1'b1, 12'had4, 32'h0000_2700);
      rtime(8'h27);
      check(32'(n >= 1020 && n <= 1284), 32'h1, "slow ramp time");
      check({24'h0, aperture_delay_o[7:0]}, 32'h0, "fine");
      wb(1'b1, 12'hae0, 32'h0000_0003);
      wb(1'b1, 12'had4, 32'h0000_1f00);
      rtime(8'h1f);
      check(32'(n >= 250 && n <= 516), 32'h1, "fast ramp time");
      wb(1'b1, 12'hae0, 32'h0);
      run <= 1'b1;
      cal(2'd0, 2'd0);
      cal(2'd1, 2'd1);
      cal(2'd2, 2'd2);
      cal(2'd3, 2'd0);
      cal(2'd0, 2'd3);
      // No edges at all: a 4096-sample run must hit the 1100-cycle period limit first
      run <= 1'b0;
      wb(1'b1, 12'hac4, 32'h0000_000d);
      wb(1'b1, 12'hac0, 32'h0000_0001);
      repeat (1200) @(posedge ref_clk_i);
      wb(1'b0, 12'hae4, 32'h0);
      check(rd, 32'h0000_0002, "fail state");
      check({31'h0, cal_complete_o}, 32'h0, "complete on fail");
      wb(1'b1, 12'hac0, 32'h0);
      stop_test();
   end
endmodule // tb_sysref_aperture_delay_cal
